/* File: hw/ezwl_zone_lock.sv */
// Purpose: zone lock query, set, freeze and locked-zone write refusal
// Assumes: frame_i comes from same-clock logic; nv inputs mirror a nonvolatile store
// Notes: answers follow the byte by one clock; lock bits are only ever set
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - four 32-byte zones, ascending address order
// - lock addresses 01h, 02h, 04h, 08h per zone
// - lock bits kept in nonvolatile storage
// - zero allows writes; one locks forever
// - query opcode 0111b write direction is acknowledged
// - lock address low nibble must match; ack
// - restart read acked, returns 00h or FFh
// - set needs opcode, lock address, FFh, all acked
// - write only on stop after acked data
// - all commands ignored during self-timed write
// - freeze opcode write direction acked unless already frozen
// - freeze keys 55h then AAh, else NACK
// - freeze written only on stop after AAh
// - frozen state blocks every lock change forever
// - array write device and word address acked
// - locked zone data byte NACKed, no write
// - stop is an empty high bit frame
module ezwl_zone_lock #(
    parameter int unsigned WRITE_TIME_NS = 5000000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // frame events and client address strap
    input wire ezwl_pkg::ezwl_frame_s frame_i,
    input wire logic [2:0] client_addr_i,
    // nonvolatile store state
    input wire logic [3:0] nv_lock_i,
    input wire logic nv_frozen_i,
    // answers to the front end
    output ezwl_pkg::ezwl_answer_s answer_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic array_write_o,
    // nonvolatile programming and status
    output ezwl_pkg::ezwl_nv_s nv_prog_o,
    output logic busy_o
);

    // longest write time, rounded down to whole cycles, never below one
    localparam int unsigned WR_RAW = WRITE_TIME_NS / ezwl_pkg::CLK_PERIOD_NS;
    localparam int unsigned WR_CYCLES = (WR_RAW < 1) ? 1 : WR_RAW;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_LK_ADDR,
        ST_LK_NEXT,
        ST_LK_RDDEV,
        ST_LK_ARMED,
        ST_FZ_ADDR,
        ST_FZ_DATA,
        ST_FZ_ARMED,
        ST_AW_ADDR,
        ST_AW_DATA,
        ST_WAIT,
        ST_BUSY
    } ezwl_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // maps a lock address nibble to a one-hot zone mask, zero when undefined
    function automatic logic [3:0] lock_mask(input logic [7:0] addr);
        logic [3:0] nib;
        nib = addr[ezwl_pkg::LOCK_ADDR_MSB:0];
        unique case (nib)
            ezwl_pkg::LOCK_ADDR_ZONE0: lock_mask = 4'h1;
            ezwl_pkg::LOCK_ADDR_ZONE1: lock_mask = 4'h2;
            ezwl_pkg::LOCK_ADDR_ZONE2: lock_mask = 4'h4;
            ezwl_pkg::LOCK_ADDR_ZONE3: lock_mask = 4'h8;
            default: lock_mask = 4'h0;
        endcase
    endfunction : lock_mask

    ezwl_state_e state_q, state_d;
    logic [7:0] dev_byte_q, dev_byte_d;
    logic [3:0] sel_q, sel_d;
    logic [1:0] zone_q, zone_d;
    logic is_freeze_q, is_freeze_d;
    logic [31:0] timer_q;
    logic start_write;
    logic timer_done;
    ezwl_pkg::ezwl_answer_s ans_d;
    logic rd_valid_d;
    logic [7:0] rd_data_d;
    logic aw_d;
    logic [3:0] opcode;
    logic [2:0] client;
    logic rw;
    logic me;
    logic [3:0] zone_in_mask;

    // device address byte fields
    assign opcode = frame_i.data[ezwl_pkg::OPCODE_MSB:ezwl_pkg::OPCODE_LSB];
    assign client = frame_i.data[ezwl_pkg::CLIENT_MSB:ezwl_pkg::CLIENT_LSB];
    assign rw = frame_i.data[ezwl_pkg::RW_BIT];
    assign me = (client == client_addr_i);
    assign zone_in_mask = lock_mask(frame_i.data);
    assign timer_done = (state_q == ST_BUSY) && (timer_q == 32'h0000_0001);

    ////////////////////////////////////////////////////////////////////////////
    // sequence decoding

    // stop outranks start, start outranks a byte; busy ignores everything
    always_comb begin
        state_d = state_q;
        dev_byte_d = dev_byte_q;
        sel_d = sel_q;
        zone_d = zone_q;
        is_freeze_d = is_freeze_q;
        ans_d = '0;
        rd_valid_d = 1'b0;
        rd_data_d = ezwl_pkg::DATA_RESET;
        aw_d = 1'b0;
        start_write = 1'b0;
        if (state_q == ST_BUSY) begin
            if (timer_done) begin
                state_d = ST_IDLE;
            end
        end else if (frame_i.stop) begin
            // empty high frame ends any sequence; only armed states program
            if (state_q == ST_LK_ARMED || state_q == ST_FZ_ARMED) begin
                state_d = ST_BUSY;
                start_write = 1'b1;
            end else begin
                state_d = ST_IDLE;
            end
        end else if (frame_i.start) begin
            // a restart only continues the lock query after its address
            state_d = (state_q == ST_LK_NEXT) ? ST_LK_RDDEV : ST_DEV;
        end else if (frame_i.byte_valid) begin
            unique case (state_q)
                ST_DEV: begin
                    dev_byte_d = frame_i.data;
                    state_d = ST_WAIT;
                    if (me && opcode == ezwl_pkg::OP_LOCK) begin
                        ans_d = '{valid: 1'b1, nack: rw};
                        if (!rw) begin
                            state_d = ST_LK_ADDR;
                        end
                    end else if (me && opcode == ezwl_pkg::OP_FREEZE) begin
                        ans_d = '{valid: 1'b1, nack: rw || nv_frozen_i};
                        if (!rw && !nv_frozen_i) begin
                            state_d = ST_FZ_ADDR;
                        end
                    end else if (me && opcode == ezwl_pkg::OP_ARRAY && !rw) begin
                        ans_d = '{valid: 1'b1, nack: 1'b0};
                        state_d = ST_AW_ADDR;
                    end
                end
                ST_LK_ADDR: begin
                    // undefined lock addresses end the request untouched
                    sel_d = zone_in_mask;
                    ans_d = '{valid: 1'b1, nack: (zone_in_mask == 4'h0)};
                    state_d = (zone_in_mask == 4'h0) ? ST_WAIT : ST_LK_NEXT;
                end
                ST_LK_NEXT: begin
                    // frozen store or wrong value refuses the set
                    if (frame_i.data == ezwl_pkg::LOCK_SET_DATA && !nv_frozen_i) begin
                        ans_d = '{valid: 1'b1, nack: 1'b0};
                        state_d = ST_LK_ARMED;
                    end else begin
                        ans_d = '{valid: 1'b1, nack: 1'b1};
                        state_d = ST_WAIT;
                    end
                end
                ST_LK_RDDEV: begin
                    state_d = ST_WAIT;
                    if (frame_i.data == {dev_byte_q[7:1], 1'b1}) begin
                        ans_d = '{valid: 1'b1, nack: 1'b0};
                        rd_valid_d = 1'b1;
                        rd_data_d = |(nv_lock_i & sel_q) ? ezwl_pkg::STATUS_SET
                                                          : ezwl_pkg::STATUS_CLEAR;
                    end
                end
                ST_FZ_ADDR: begin
                    ans_d = '{valid: 1'b1,
                              nack: (frame_i.data != ezwl_pkg::FREEZE_KEY_ADDR)};
                    state_d = (frame_i.data == ezwl_pkg::FREEZE_KEY_ADDR) ? ST_FZ_DATA : ST_WAIT;
                end
                ST_FZ_DATA: begin
                    ans_d = '{valid: 1'b1,
                              nack: (frame_i.data != ezwl_pkg::FREEZE_KEY_DATA)};
                    state_d = (frame_i.data == ezwl_pkg::FREEZE_KEY_DATA) ? ST_FZ_ARMED : ST_WAIT;
                end
                ST_AW_ADDR: begin
                    // word address is acknowledged whatever zone it hits
                    zone_d = frame_i.data[ezwl_pkg::ZONE_SEL_MSB:ezwl_pkg::ZONE_SEL_LSB];
                    ans_d = '{valid: 1'b1, nack: 1'b0};
                    state_d = ST_AW_DATA;
                end
                ST_AW_DATA: begin
                    // locked zone refuses at once and frees the device
                    ans_d = '{valid: 1'b1, nack: nv_lock_i[zone_q]};
                    aw_d = !nv_lock_i[zone_q];
                    state_d = nv_lock_i[zone_q] ? ST_IDLE : ST_WAIT;
                end
                ST_LK_ARMED, ST_FZ_ARMED: begin
                    // extra byte disarms rather than programming a guess
                    ans_d = '{valid: 1'b1, nack: 1'b1};
                    state_d = ST_WAIT;
                end
                ST_IDLE, ST_WAIT, ST_BUSY: begin
                    state_d = state_q;
                end
            endcase
        end
        if (start_write) begin
            is_freeze_d = (state_q == ST_FZ_ARMED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence state

    // sequence registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            dev_byte_q <= ezwl_pkg::DATA_RESET;
            sel_q <= ezwl_pkg::LOCK_RESET;
            zone_q <= 2'h0;
            is_freeze_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dev_byte_q <= dev_byte_d;
            sel_q <= sel_d;
            zone_q <= zone_d;
            is_freeze_q <= is_freeze_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-timed write

    // counts the write time; reset aborts it, which the host must avoid
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            timer_q <= 32'h0000_0000;
        end else if (start_write) begin
            timer_q <= WR_CYCLES[31:0];
        end else if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
        end
    end

    // programming pulse at the end of the write; bits are only ever set
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            nv_prog_o <= '0;
        end else if (timer_done) begin
            nv_prog_o.lock_set <= is_freeze_q ? ezwl_pkg::LOCK_RESET : sel_q;
            nv_prog_o.freeze_set <= is_freeze_q;
        end else begin
            nv_prog_o <= '0;
        end
    end

    // busy flag mirrors the write window
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_d == ST_BUSY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answers

    // registered answers, one clock after the byte
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            answer_o <= '0;
            rd_valid_o <= 1'b0;
            rd_data_o <= ezwl_pkg::DATA_RESET;
            array_write_o <= 1'b0;
        end else begin
            answer_o <= ans_d;
            rd_valid_o <= rd_valid_d;
            rd_data_o <= rd_data_d;
            array_write_o <= aw_d;
        end
    end

endmodule : ezwl_zone_lock

/* File: inc/ezwl_pkg.sv */
// Purpose: shared constants and carriers of the zone write lock block
// Assumes: a bit-frame front end on the same clock delivers start, stop and bytes
// Notes: lock state itself lives in an outside nonvolatile store
package ezwl_pkg;

    // device address byte layout
    localparam int OPCODE_MSB = 7;
    localparam int OPCODE_LSB = 4;
    localparam int CLIENT_MSB = 3;
    localparam int CLIENT_LSB = 1;
    localparam int RW_BIT = 0;

    // opcodes handled here
    localparam logic [3:0] OP_LOCK = 4'h7;
    localparam logic [3:0] OP_FREEZE = 4'h1;
    localparam logic [3:0] OP_ARRAY = 4'hA;

    // zone geometry: four zones of 32 bytes, zone index in word address bits 6:5
    localparam int ZONE_COUNT = 4;
    localparam int ZONE_SEL_MSB = 6;
    localparam int ZONE_SEL_LSB = 5;

    // lock addresses, only the low nibble is decoded
    localparam logic [3:0] LOCK_ADDR_ZONE0 = 4'h1;
    localparam logic [3:0] LOCK_ADDR_ZONE1 = 4'h2;
    localparam logic [3:0] LOCK_ADDR_ZONE2 = 4'h4;
    localparam logic [3:0] LOCK_ADDR_ZONE3 = 4'h8;
    localparam int LOCK_ADDR_MSB = 3;

    // key and data values
    localparam logic [7:0] LOCK_SET_DATA = 8'hFF;
    localparam logic [7:0] FREEZE_KEY_ADDR = 8'h55;
    localparam logic [7:0] FREEZE_KEY_DATA = 8'hAA;
    localparam logic [7:0] STATUS_CLEAR = 8'h00;
    localparam logic [7:0] STATUS_SET = 8'hFF;

    // reset values
    localparam logic [3:0] LOCK_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 5;

    // frame events from the bit front end, one-cycle pulses
    typedef struct packed {
        logic start;
        logic stop;
        logic byte_valid;
        logic [7:0] data;
    } ezwl_frame_s;

    // acknowledge decision for the byte just received
    typedef struct packed {
        logic valid;
        logic nack;
    } ezwl_answer_s;

    // programming request to the nonvolatile store
    typedef struct packed {
        logic [3:0] lock_set;
        logic freeze_set;
    } ezwl_nv_s;

endpackage : ezwl_pkg

/* File: test/ezwl_nv_model.sv */
// Purpose: nonvolatile lock store beside the zone lock block
// Assumes: programming pulses arrive on the block clock
// Notes: no reset input, so state outlives every block reset
`timescale 1ns/1ps
module ezwl_nv_model (
    // clock
    input wire logic clock_i,
    // programming pulses
    input wire ezwl_pkg::ezwl_nv_s prog_i,
    // stored state
    output logic [3:0] lock_o,
    output logic frozen_o
);
    // cells start erased
    initial begin
        lock_o = ezwl_pkg::LOCK_RESET;
        frozen_o = 1'b0;
    end
    // bits can only be set, never cleared
    always @(posedge clock_i) begin
        lock_o <= lock_o | prog_i.lock_set;
        frozen_o <= frozen_o | prog_i.freeze_set;
    end
endmodule : ezwl_nv_model

/* File: test/ezwl_zone_lock_assertions.sv */
// Purpose: port checker for the zone lock block
// Assumes: one clock domain, reset asynchronous active high
// Notes: start to byte spacing in seq_freeze_op matches the bench
`timescale 1ns/1ps
module ezwl_zone_lock_assertions #(
    parameter int unsigned WRITE_TIME_NS = 5000000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // inputs
    input wire ezwl_pkg::ezwl_frame_s frame_i,
    input wire logic [2:0] client_addr_i,
    input wire logic nv_frozen_i,
    // outputs
    input wire ezwl_pkg::ezwl_answer_s answer_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic array_write_o,
    input wire ezwl_pkg::ezwl_nv_s nv_prog_o,
    input wire logic busy_o
);
    localparam int unsigned WR_RAW = WRITE_TIME_NS / ezwl_pkg::CLK_PERIOD_NS;
    localparam int unsigned WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
    logic [31:0] busy_cnt_q;
    ////////////////////////////////////////
    // length of the current busy stretch
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // freeze opcode for this client, two cycles after start
    sequence seq_freeze_op;
        frame_i.start && !busy_o ##2 frame_i.byte_valid
            && frame_i.data == {ezwl_pkg::OP_FREEZE, client_addr_i, 1'b0};
    endsequence
    ans_cause_a: assert property (answer_o.valid |-> $past(frame_i.byte_valid))
        else $error("answer with no byte");
    busy_quiet_a: assert property (answer_o.valid |-> !$past(busy_o))
        else $error("answer while busy");
    rd_ack_a: assert property (rd_valid_o |-> answer_o.valid && !answer_o.nack)
        else $error("status without ack");
    rd_value_a: assert property (rd_valid_o ? rd_data_o inside {8'h00, 8'hFF} : rd_data_o == 8'h00)
        else $error("bad status byte");
    aw_ack_a: assert property (array_write_o |-> answer_o.valid && !answer_o.nack)
        else $error("array write without ack");
    busy_start_a: assert property ($rose(busy_o) |-> $past(frame_i.stop) || $past(frame_i.stop, 2))
        else $error("write began without stop");
    prog_end_a: assert property (($fell(busy_o) || (|nv_prog_o)) |-> $fell(busy_o) && $onehot(nv_prog_o))
        else $error("program pulse not at write end");
    busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_q == WR_CYC)
        else $error("write time wrong");
    frozen_nack_a: assert property (seq_freeze_op ##0 nv_frozen_i |=> answer_o.valid && answer_o.nack)
        else $error("freeze acked when frozen");
    frozen_lock_a: assert property (nv_frozen_i |-> nv_prog_o.lock_set == 4'h0)
        else $error("lock set after freeze");
endmodule : ezwl_zone_lock_assertions

/* File: test/ezwl_zone_lock_tb.sv */
// Purpose: self-checking bench for the zone lock block
// Assumes: nonvolatile store is the ezwl_nv_model partner
// Notes: write time shortened to 10 cycles
`timescale 1ns/1ps
module ezwl_zone_lock_tb;
    localparam logic [1:0] ACK = 2'b10;
    localparam logic [1:0] NAK = 2'b11;
    localparam logic [1:0] NONE = 2'b00;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    ezwl_pkg::ezwl_frame_s frame = '0;
    ezwl_pkg::ezwl_answer_s answer;
    ezwl_pkg::ezwl_nv_s prog;
    logic rd_v, aw, busy, frozen, aw_q;
    logic [7:0] rd_d, rd_q;
    logic [3:0] lock;
    logic [3:0] exp_lock = 4'h0;
    int errors = 0;
    int total_checks = 0;
    // 200 MHz clock
    always #2.5 clock_i = ~clock_i;
    ezwl_zone_lock #(.WRITE_TIME_NS(50)) dut (
        .clock_i(clock_i), .reset_i(reset_i), .frame_i(frame), .client_addr_i(3'h5),
        .nv_lock_i(lock), .nv_frozen_i(frozen), .answer_o(answer), .rd_valid_o(rd_v),
        .rd_data_o(rd_d), .array_write_o(aw), .nv_prog_o(prog), .busy_o(busy));
    ezwl_nv_model nv (.clock_i(clock_i), .prog_i(prog), .lock_o(lock), .frozen_o(frozen));
    ////////////////////////////////////////
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check_val
    function automatic logic [7:0] dev(input logic [3:0] op, input logic rw);
        return {op, 3'h5, rw};
    endfunction : dev
    // kind 1 start, 2 stop, 3 byte; outputs caught after the taking edge
    task automatic send(input logic [1:0] kind, input logic [7:0] b);
        @(posedge clock_i);
        frame.start <= kind == 2'd1;
        frame.stop <= kind == 2'd2;
        frame.byte_valid <= kind == 2'd3;
        frame.data <= b;
        @(posedge clock_i);
        frame <= '0;
        #1;
        rd_q = rd_v ? rd_d : 8'h5A;
        aw_q = aw;
    endtask : send
    task automatic bt(input logic [7:0] b, input logic [1:0] exp);
        send(2'd3, b);
        check_val({answer.valid, answer.valid & answer.nack}, exp);
    endtask : bt
    task automatic wait_idle;
        int n;
        n = 0;
        // frame left quiet while waiting; the block ignores frames during the write anyway
        while (busy === 1'b1 && n < 100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check_val(busy, 1'b0);
        repeat (2) @(posedge clock_i);
        #1;
    endtask : wait_idle
    task automatic lock_prefix(input logic [7:0] a, input logic [1:0] ea);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_LOCK, 1'b0), ACK);
        bt(a, ea);
    endtask : lock_prefix
    task automatic t_query(input logic [7:0] a, input logic [7:0] exp);
        lock_prefix(a, ACK);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_LOCK, 1'b1), ACK);
        check_val(rd_q, exp);
        send(2'd2, 8'h00);
        $display("query %0h done", a);
    endtask : t_query
    task automatic t_lock(input logic [7:0] a, input logic [1:0] ed, input logic eb);
        lock_prefix(a, ACK);
        bt(ezwl_pkg::LOCK_SET_DATA, ed);
        send(2'd2, 8'h00);
        @(posedge clock_i);
        #1;
        check_val(busy, eb);
        if (eb) begin
            send(2'd1, 8'h00);
            bt(dev(ezwl_pkg::OP_LOCK, 1'b0), NONE);
            wait_idle;
            exp_lock = exp_lock | a[3:0];
        end
        check_val(lock, exp_lock);
        $display("lock set %0h done", a);
    endtask : t_lock
    task automatic t_abort(input logic [7:0] a, input logic [1:0] ea);
        lock_prefix(a, ea);
        send(2'd2, 8'h00);
        repeat (2) @(posedge clock_i);
        #1;
        check_val({busy, lock}, {1'b0, exp_lock});
        $display("abort %0h done", a);
    endtask : t_abort
    task automatic t_array(input logic [7:0] wa);
        logic lk;
        lk = exp_lock[wa[6:5]];
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_ARRAY, 1'b0), ACK);
        bt(wa, ACK);
        bt(8'h3C, lk ? NAK : ACK);
        check_val(aw_q, !lk);
        send(2'd2, 8'h00);
        $display("array %0h done", wa);
    endtask : t_array
    task automatic t_freeze;
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_FREEZE, 1'b0), ACK);
        bt(8'h56, NAK);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_FREEZE, 1'b0), ACK);
        bt(ezwl_pkg::FREEZE_KEY_ADDR, ACK);
        bt(8'h55, NAK);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_FREEZE, 1'b0), ACK);
        bt(ezwl_pkg::FREEZE_KEY_ADDR, ACK);
        send(2'd2, 8'h00);
        @(posedge clock_i);
        #1;
        check_val({busy, frozen}, 2'b00);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_FREEZE, 1'b0), ACK);
        bt(ezwl_pkg::FREEZE_KEY_ADDR, ACK);
        bt(ezwl_pkg::FREEZE_KEY_DATA, ACK);
        send(2'd2, 8'h00);
        @(posedge clock_i);
        #1;
        check_val(busy, 1'b1);
        wait_idle;
        check_val(frozen, 1'b1);
        send(2'd1, 8'h00);
        bt(dev(ezwl_pkg::OP_FREEZE, 1'b0), NAK);
        send(2'd2, 8'h00);
        t_lock(8'h01, NAK, 1'b0);
        $display("freeze done");
    endtask : t_freeze
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        for (int i = 0; i < ezwl_pkg::ZONE_COUNT; i++) begin
            t_query(8'hF0 | (8'h01 << i), 8'h00);
        end
        t_abort(8'h03, NAK);
        t_abort(8'h04, ACK);
        t_lock(8'h04, ACK, 1'b1);
        t_query(8'h04, 8'hFF);
        // last byte of every zone, then the first byte of the locked one
        for (int i = 0; i < ezwl_pkg::ZONE_COUNT; i++) begin
            t_array(8'h1F + 8'h20 * i[7:0]);
        end
        t_array(8'h40);
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        t_query(8'h04, 8'hFF);
        t_freeze;
        finish_test;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        finish_test;
    end
endmodule : ezwl_zone_lock_tb
bind ezwl_zone_lock ezwl_zone_lock_assertions #(.WRITE_TIME_NS(WRITE_TIME_NS)) chk (
    .clock_i(clock_i), .reset_i(reset_i), .frame_i(frame_i), .client_addr_i(client_addr_i),
    .nv_frozen_i(nv_frozen_i), .answer_o(answer_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .array_write_o(array_write_o), .nv_prog_o(nv_prog_o),
    .busy_o(busy_o));
